// ===== design/ocr_routing.sv
// output clock routing control: registers 0x21..0x24, source muxes and output gating
//
// Operation
// R1 - bit 7 of the third-output register makes the third output free-running at 0 and stoppable at 1, resets to 1.
// R2 - the mux register picks each output's source (bits 7:6, 5:4, 3:2) among third divider, fifth, first, rtc clock.
// R3 - mux register bits 1:0 pick the first divider's input: first loop, reference, or fourth divider seed for 1x.
// R4 - bits 1:0 at 0x24 pick the fourth divider's input from four sources and reset to 11.
// R5 - bit 7 at 0x24 powers the chip down when cleared and restores operation when set, resetting to 1.
// R6 - bit 6 at 0x24 lets the reference run freely on outputs two and three, bit 5 widens it from two to both.
// R7 - bit 3 at 0x24 makes the first output stoppable, bit 2 enables the enable-pin function of outputs two and three.
// R8 - the host writes reserved bits only with their defaults and does not rely on their read value; the bench checks them, reading 0x22 against 0x84.
`default_nettype none
`include "ocr_map.svh"
module ocr_routing (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire ocr_pkg::ocr_addr_t reg_addr,
   input wire ocr_pkg::ocr_byte_t reg_wdata,
   output ocr_pkg::ocr_byte_t reg_rdata_q,
   input wire logic third_divider,
   input wire logic fifth_divider,
   input wire logic first_divider,
   input wire logic low_rate_rtc_clock,
   input wire logic first_synth_loop,
   input wire logic ref_clk,
   input wire logic fourth_divider_seed_out,
   input wire logic second_loop_channel_two,
   input wire logic third_loop_channel_two,
   input wire logic third_divider_seed,
   input wire logic fifth_divider_seed,
   input wire logic stop_req,
   input wire logic second_out_stoppable,
   input wire logic oe2_pin,
   input wire logic oe3_pin,
   output logic first_output_q,
   output logic second_output_q,
   output logic third_output_q,
   output logic first_divider_in_q,
   output logic fourth_divider_in_q,
   output logic chip_powerdown_n_q
);
   import ocr_pkg::*;

   // ==================================================
   // register file
   ocr_byte_t third_run_q;
   ocr_byte_t src_sel_q;
   ocr_byte_t pwr_ctrl_q;
   logic wr_third;
   logic wr_src;
   logic wr_pwr;
   ocr_byte_t rd_mux;
   ocr_byte_t third_run_d;
   ocr_byte_t pwr_ctrl_d;

   assign wr_third = reg_wr && (reg_addr == `OCR_OFS_THIRD_RUN);
   assign wr_src = reg_wr && (reg_addr == `OCR_OFS_SRC_SEL);
   assign wr_pwr = reg_wr && (reg_addr == `OCR_OFS_PWR_CTRL);
   // at 0x21 only the stoppable bit is storage; reserved bits keep their reset pattern
   assign third_run_d = (`OCR_RST_THIRD_RUN & 8'h7f) | (reg_wdata & 8'h80); // [R1]
   assign pwr_ctrl_d = reg_wdata | (8'h01 << `OCR_BIT_PWR_RSVD);
   assign rd_mux = (reg_addr == `OCR_OFS_THIRD_RUN) ? third_run_q :
                   (reg_addr == `OCR_OFS_RSVD_A) ? `OCR_RST_RSVD_A :
                   (reg_addr == `OCR_OFS_SRC_SEL) ? src_sel_q :
                   (reg_addr == `OCR_OFS_PWR_CTRL) ? pwr_ctrl_q : 8'h00;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         third_run_q <= `OCR_RST_THIRD_RUN; // [R1]
         src_sel_q <= `OCR_RST_SRC_SEL;
         pwr_ctrl_q <= `OCR_RST_PWR_CTRL; // [R4] [R5] [R7]
      end else begin
         if (wr_third) begin
            third_run_q <= third_run_d;
         end
         if (wr_src) begin
            src_sel_q <= reg_wdata; // [R2] [R3]
         end
         if (wr_pwr) begin
            pwr_ctrl_q <= pwr_ctrl_d;
         end
      end
   end

   // rdata holds its last value between reads; unmapped offsets read zero
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata_q <= 8'h00;
      end else if (reg_rd) begin
         reg_rdata_q <= rd_mux;
      end
   end

   // ==================================================
   // field decode
   logic third_stoppable;
   logic first_stoppable;
   logic powerdown_n;
   logic ref_free_run;
   logic both_free_run;
   logic enable_pin_func;
   logic [1:0] first_div_sel;
   logic [1:0] fourth_div_sel;
   logic [5:0] out_sel;

   assign third_stoppable = third_run_q[`OCR_BIT_THIRD_STOPPABLE];
   assign first_stoppable = pwr_ctrl_q[`OCR_BIT_FIRST_STOPPABLE];
   assign powerdown_n = pwr_ctrl_q[`OCR_BIT_POWERDOWN_N];
   assign ref_free_run = pwr_ctrl_q[`OCR_BIT_REF_FREE_RUN];
   assign both_free_run = pwr_ctrl_q[`OCR_BIT_BOTH_FREE_RUN];
   assign enable_pin_func = pwr_ctrl_q[`OCR_BIT_ENABLE_PIN_FUNC];
   // 1x collapses to the seed input, so bit 0 is don't-care once bit 1 is set
   assign first_div_sel = src_sel_q[`OCR_LSB_FIRST_DIV_SRC + 1] ? 2'h2 : src_sel_q[`OCR_LSB_FIRST_DIV_SRC +: 2]; // [R3]
   assign fourth_div_sel = pwr_ctrl_q[`OCR_LSB_FOURTH_DIV_SRC +: 2]; // [R4]
   assign out_sel = src_sel_q[`OCR_LSB_THIRD_SRC + 1:`OCR_LSB_FIRST_SRC]; // [R2]

   // ==================================================
   // source muxes
   logic [2:0] out_src_q;
   logic [3:0] out_pool;

   assign out_pool = {low_rate_rtc_clock, first_divider, fifth_divider, third_divider};

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_out_mux
         ocr_sel4 u_sel (
            .clock(clock),
            .rst_n(rst_n),
            .sel(out_sel[2*gi +: 2]),
            .src(out_pool),
            .out_q(out_src_q[gi])
         ); // [R2]
      end
   endgenerate

   ocr_sel4 u_first_div (
      .clock(clock),
      .rst_n(rst_n),
      .sel(first_div_sel),
      .src({fourth_divider_seed_out, fourth_divider_seed_out, ref_clk, first_synth_loop}),
      .out_q(first_divider_in_q)
   ); // [R3]

   ocr_sel4 u_fourth_div (
      .clock(clock),
      .rst_n(rst_n),
      .sel(fourth_div_sel),
      .src({fifth_divider_seed, third_divider_seed, third_loop_channel_two, second_loop_channel_two}),
      .out_q(fourth_divider_in_q)
   ); // [R4]

   // ==================================================
   // output gating
   logic stop1;
   logic stop2;
   logic stop3;
   logic ref2;
   logic ref3;
   logic pin_off2;
   logic pin_off3;
   logic first_output_d;
   logic second_output_d;
   logic third_output_d;

   assign stop1 = stop_req && first_stoppable; // [R7]
   assign stop2 = stop_req && second_out_stoppable;
   assign stop3 = stop_req && third_stoppable; // [R1]
   // a stopped output may still carry the reference when free-run is granted to it
   assign ref2 = stop2 && ref_free_run; // [R6]
   assign ref3 = stop3 && ref_free_run && both_free_run; // [R6]
   assign pin_off2 = enable_pin_func && !oe2_pin; // [R7]
   assign pin_off3 = enable_pin_func && !oe3_pin; // [R7]
   assign first_output_d = powerdown_n && !stop1 && out_src_q[0]; // [R5]
   assign second_output_d = powerdown_n && !pin_off2 && (ref2 ? ref_clk : (!stop2 && out_src_q[1]));
   assign third_output_d = powerdown_n && !pin_off3 && (ref3 ? ref_clk : (!stop3 && out_src_q[2]));

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         first_output_q <= 1'b0;
         second_output_q <= 1'b0;
         third_output_q <= 1'b0;
         chip_powerdown_n_q <= 1'b1;
      end else begin
         first_output_q <= first_output_d;
         second_output_q <= second_output_d;
         third_output_q <= third_output_d;
         chip_powerdown_n_q <= powerdown_n; // [R5]
      end
   end

   // ==================================================
   // assertions
   sequence s_rtc_on_first;
      out_sel[1:0] == 2'h3 ##1 (powerdown_n && !stop1 && $stable(out_sel[1:0]));
   endsequence

   chk_third_stop_gate: assert property (@(posedge clock) disable iff (!rst_n) // [R1]
      (stop3 && !ref3) |=> !third_output_q)
      else $error("third output not held low while stopped");
   chk_third_wr_bit: assert property (@(posedge clock) disable iff (!rst_n) // [R1]
      wr_third |=> (third_stoppable == $past(reg_wdata[7])) && (third_run_q[6:0] == 7'h00))
      else $error("third output control register write wrong");
   chk_first_rtc_src: assert property (@(posedge clock) disable iff (!rst_n) // [R2]
      s_rtc_on_first |=> first_output_q == $past(low_rate_rtc_clock, 2))
      else $error("first output not following rtc clock");
   chk_first_div_seed: assert property (@(posedge clock) disable iff (!rst_n) // [R3]
      src_sel_q[1] |=> first_divider_in_q == $past(fourth_divider_seed_out))
      else $error("first divider not fed by fourth divider seed");
   chk_fourth_div_src: assert property (@(posedge clock) disable iff (!rst_n) // [R4]
      pwr_ctrl_q[1:0] == 2'h0 |=> fourth_divider_in_q == $past(second_loop_channel_two))
      else $error("fourth divider source wrong");
   chk_chip_pwr_down: assert property (@(posedge clock) disable iff (!rst_n) // [R5]
      !powerdown_n |=> !first_output_q && !second_output_q && !third_output_q && !chip_powerdown_n_q)
      else $error("outputs alive during power down");
   chk_ref_free_run: assert property (@(posedge clock) disable iff (!rst_n) // [R6]
      (powerdown_n && !pin_off3 && stop3 && ref_free_run && both_free_run) |=> third_output_q == $past(ref_clk))
      else $error("reference not running on third output");
   chk_second_ref_run: assert property (@(posedge clock) disable iff (!rst_n) // [R6]
      (powerdown_n && !pin_off2 && stop2 && ref_free_run) |=> second_output_q == $past(ref_clk))
      else $error("reference not running on second output");
   chk_pin_func_off: assert property (@(posedge clock) disable iff (!rst_n) // [R7]
      (pin_off2 || (powerdown_n && stop1)) |=> (!second_output_q || !$past(pin_off2)) && (!first_output_q || !$past(stop1)))
      else $error("enable pin or first stop not honoured");
endmodule
`default_nettype wire

// ===== design/ocr_map.svh
// register offsets, field positions and reset values of the output routing block
`ifndef OCR_MAP_SVH
`define OCR_MAP_SVH

// ==================================================
// register offsets
`define OCR_OFS_THIRD_RUN 8'h21
`define OCR_OFS_RSVD_A 8'h22
`define OCR_OFS_SRC_SEL 8'h23
`define OCR_OFS_PWR_CTRL 8'h24

// ==================================================
// reset values
`define OCR_RST_THIRD_RUN 8'h80
`define OCR_RST_RSVD_A 8'h84
`define OCR_RST_SRC_SEL 8'h8d
`define OCR_RST_PWR_CTRL 8'h9b

// ==================================================
// field positions
`define OCR_BIT_THIRD_STOPPABLE 7
`define OCR_LSB_THIRD_SRC 6
`define OCR_LSB_SECOND_SRC 4
`define OCR_LSB_FIRST_SRC 2
`define OCR_LSB_FIRST_DIV_SRC 0
`define OCR_BIT_POWERDOWN_N 7
`define OCR_BIT_REF_FREE_RUN 6
`define OCR_BIT_BOTH_FREE_RUN 5
`define OCR_BIT_PWR_RSVD 4
`define OCR_BIT_FIRST_STOPPABLE 3
`define OCR_BIT_ENABLE_PIN_FUNC 2
`define OCR_LSB_FOURTH_DIV_SRC 0

`endif

// ===== design/ocr_pkg.sv
// types shared by the output routing block
`default_nettype none
package ocr_pkg;
   typedef logic [7:0] ocr_byte_t;
   typedef logic [7:0] ocr_addr_t;
   // source code of an output clock mux
   typedef enum logic [1:0] {
      OCR_OUT_THIRD_DIV = 2'h0,
      OCR_OUT_FIFTH_DIV = 2'h1,
      OCR_OUT_FIRST_DIV = 2'h2,
      OCR_OUT_RTC = 2'h3
   } ocr_out_src_t;
endpackage
`default_nettype wire

// ===== design/ocr_sel4.sv
// four-way source select with registered result
`default_nettype none
module ocr_sel4 (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [1:0] sel,
   input wire logic [3:0] src,
   output logic out_q
);
   logic pick;
   assign pick = src[sel];
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         out_q <= 1'b0;
      end else begin
         out_q <= pick;
      end
   end
endmodule
`default_nettype wire

// ===== dv/ocr_host.sv
// host model driving the register port of the routing block
`default_nettype none
module ocr_host (
   input wire logic clock,
   input wire ocr_pkg::ocr_byte_t reg_rdata_q,
   output logic reg_wr,
   output logic reg_rd,
   output ocr_pkg::ocr_addr_t reg_addr,
   output ocr_pkg::ocr_byte_t reg_wdata
);
   timeunit 1ns;
   timeprecision 1ns;
   import ocr_pkg::*;
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
   end
   // ==========
   // bus cycles
   // released lines show the inverse so a stale value cannot pass
   task automatic wr(input ocr_addr_t a, input ocr_byte_t d);
      @(posedge clock);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= (a == 8'h21) ? (d & 8'h80) : ((a == 8'h24) ? (d | 8'h10) : d);
      @(posedge clock);
      reg_wr <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~reg_wdata;
   endtask
   task automatic rd(input ocr_addr_t a, output ocr_byte_t d);
      @(posedge clock);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      @(posedge clock);
      d = reg_rdata_q;
   endtask
endmodule
`default_nettype wire

// ===== dv/tb.sv
// self-checking bench of the output routing block
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   import ocr_pkg::*;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic reg_wr, reg_rd, pd_n;
   ocr_addr_t reg_addr;
   ocr_byte_t reg_wdata, reg_rdata_q, rv, sel, pwr, third;
   ocr_byte_t ra[5] = '{8'h21, 8'h22, 8'h23, 8'h24, 8'h30};
   ocr_byte_t re[5] = '{8'h80, 8'h84, 8'h8d, 8'h9b, 8'h00};
   // sources 0..10, stop 11, second stoppable 12, enable pins 13..14
   logic [14:0] src = '0;
   logic [4:0] outs;
   int n_fail = 0;
   int num_checks = 0;
   int cyc = 0;
   int seed = 32'h05644d32;
   always #25 clock = ~clock;
   ocr_host i_host (.clock(clock), .reg_rdata_q(reg_rdata_q), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata));
   ocr_routing i_dut (.clock(clock), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .third_divider(src[0]), .fifth_divider(src[1]),
      .first_divider(src[2]), .low_rate_rtc_clock(src[3]), .first_synth_loop(src[4]), .ref_clk(src[5]),
      .fourth_divider_seed_out(src[6]), .second_loop_channel_two(src[7]), .third_loop_channel_two(src[8]),
      .third_divider_seed(src[9]), .fifth_divider_seed(src[10]), .stop_req(src[11]),
      .second_out_stoppable(src[12]), .oe2_pin(src[13]), .oe3_pin(src[14]), .first_output_q(outs[0]),
      .second_output_q(outs[1]), .third_output_q(outs[2]), .first_divider_in_q(outs[3]),
      .fourth_divider_in_q(outs[4]), .chip_powerdown_n_q(pd_n));
   // ==========
   // expectation and reporting
   // order: power down, then enable pin, then stop with reference free-run
   function automatic logic [4:0] exp_outs(input logic [14:0] s, input ocr_byte_t m, p, t);
      logic [2:0] o, stp, fr;
      o = {s[m[7:6]], s[m[5:4]], s[m[3:2]]};
      stp = {t[7], s[12], p[3]} & {3{s[11]}};
      fr = {p[6] & p[5] & s[5], p[6] & s[5], 1'b0};
      o = (o & ~stp) | (fr & stp);
      o = o & {~(p[2] & ~s[14]), ~(p[2] & ~s[13]), 1'b1} & {3{p[7]}};
      return {s[4'd7 + {2'b0, p[1:0]}], m[1] ? s[6] : (m[0] ? s[5] : s[4]), o};
   endfunction
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         summarize();
      end
   end
   // ==========
   // main sequence
   initial begin
      repeat (20) @(posedge clock);
      rst_n <= 1'b1;
      #1;
      check("power copy", {7'h0, pd_n}, 8'h01);
      i_host.wr(8'h30, 8'hff);
      foreach (ra[i]) begin
         i_host.rd(ra[i], rv);
         check("reset read", rv, re[i]);
      end
      // first four rounds walk every select code with power on
      for (int k = 0; k < 60; k++) begin
         sel = (k < 4) ? 8'h55 * k[7:0] : 8'($random(seed));
         pwr = (k < 4) ? {6'h24, k[1:0]} : 8'($random(seed)) | 8'h10;
         third = 8'($random(seed)) & 8'h80;
         i_host.wr(8'h21, third);
         i_host.wr(8'h23, sel);
         i_host.wr(8'h24, pwr);
         src <= 15'($random(seed));
         repeat (4) @(posedge clock);
         #1;
         check("routing", {3'h0, outs}, {3'h0, exp_outs(src, sel, pwr, third)});
         check("power copy", {7'h0, pd_n}, {7'h0, pwr[7]});
         i_host.rd(8'h24, rv);
         check("control read", rv, pwr);
         i_host.rd(8'h21, rv);
         check("third read", rv, third);
      end
      summarize();
   end
endmodule
`default_nettype wire
